/* File: shared/modem_flow_pkg.sv */
package modem_flow_pkg;
    // AXI4-Lite register map (byte addresses)
    localparam logic [7:0] ADDR_MODEM_LINE_STATUS  = 8'h00;
    localparam logic [7:0] ADDR_FLOW_LEVELS        = 8'h04;
    localparam logic [7:0] ADDR_MODEM_CONTROL      = 8'h08;
    localparam logic [7:0] ADDR_FEATURE_CTRL       = 8'h0c;
    localparam logic [7:0] ADDR_FIFO_FLOW          = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STATUS         = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK           = 8'h18;
    // Field positions
    localparam int MCR_LOOP_BIT   = 4;
    localparam int MCR_OP2_BIT    = 3;
    localparam int MCR_OP1_BIT    = 2;
    localparam int MCR_RTS_BIT    = 1;
    localparam int MCR_DTR_BIT    = 0;
    localparam int EFR_ENH_BIT    = 4;
    localparam int SFR_SEL_BIT    = 2;
    localparam int FEAT_EFR_LSB   = 0;
    localparam int FEAT_SFR_LSB   = 8;
    localparam int FLOW_RTS_EN    = 0;
    localparam int FLOW_SW_EN     = 1;
    localparam int FLOW_CNT_LSB   = 8;
    localparam int FLOW_RTS_OUT   = 16;
    localparam int FLOW_XOFF_SENT = 17;
    localparam int LEVEL_SCALE    = 4;
    // Reset values
    localparam logic [7:0] MCR_RESET   = 8'h00;
    localparam logic [7:0] LEVEL_RESET = 8'h00;
    localparam logic [7:0] EFR_RESET   = 8'h00;
    localparam logic [7:0] SFR_RESET   = 8'h00;
    localparam logic [1:0] IRQ_RESET   = 2'h0;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : modem_flow_pkg

/* File: shared/modem_in_if.sv */
`timescale 1ns/1ps
interface modem_in_if;
    logic [3:0] level;   // Active-high: cd, ri, dsr, cts
    logic [3:0] delta;   // One-cycle change pulses
    modport sync_side (output level, output delta);
    modport user_side (input level, input delta);
endinterface : modem_in_if

/* File: design/modem_input_sync.sv */
`timescale 1ns/1ps
module modem_input_sync
    import modem_flow_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [3:0] pins_n_i,
    modem_in_if.sync_side   mi
);
    logic [3:0] meta_q;
    logic [3:0] sync_q;
    logic [3:0] prev_q;
    logic       primed_q;

    // Two stages; only the second stage feeds change detection
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= 4'hf;
            sync_q <= 4'hf;
        end
        else
        begin
            meta_q <= pins_n_i;
            sync_q <= meta_q;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            prev_q   <= 4'hf;
            primed_q <= 1'b0;
        end
        else
        begin
            prev_q   <= sync_q;
            primed_q <= 1'b1;
        end
    end

    // Priming masks only the first cycle after reset; a pin active at reset still flags a delta as the reset value drains away
    genvar g;
    for (g = 0; g < 4; g++)
    begin : g_ch
        assign mi.level[g] = ~sync_q[g];
        assign mi.delta[g] = primed_q & (sync_q[g] ^ prev_q[g]); // [R19]
    end
endmodule : modem_input_sync

/* File: design/modem_status_flow.sv */
// What this block does
// [R1] Bit7 is not carrier, loopback uses control bit3
// [R2] Bit6 is not ring, loopback uses control bit2
// [R3] Bit5 is not dsr, loopback uses control bit0
// [R4] Bit4 is not cts, loopback uses control bit1
// [R5] Bit3 flags any carrier change
// [R6] Bit2 flags ring low-to-high only
// [R7] Bit1 flags any dsr change
// [R8] Bit0 flags any cts change
// [R9] Enabled delta flag raises modem interrupt
// [R10] Levels register gated by feature bits
// [R11] Rts reasserted at or below resume level
// [R12] Xon sent at or below resume level
// [R13] Rts dropped at or above halt level
// [R14] Xoff sent at or above halt level
// [R15] Software keeps resume below trigger level
// [R16] Software keeps halt above trigger level
// [R17] Control bit4 selects internal loopback
// [R18] Status read clears delta flags
// [R19] Inputs synchronised before change detection
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
module modem_status_flow
    import modem_flow_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        carrier_detect_n_i,
    input  wire logic        ring_indicator_n_i,
    input  wire logic        data_set_ready_n_i,
    input  wire logic        clear_to_send_n_i,
    input  wire logic [6:0]  rx_fifo_count_i,
    input  wire logic [7:0]  awaddr_i,
    input  wire logic        awvalid_i,
    output logic             awready_o,
    input  wire logic [31:0] wdata_i,
    input  wire logic [3:0]  wstrb_i,
    input  wire logic        wvalid_i,
    output logic             wready_o,
    output logic [1:0]       bresp_o,
    output logic             bvalid_o,
    input  wire logic        bready_i,
    input  wire logic [7:0]  araddr_i,
    input  wire logic        arvalid_i,
    output logic             arready_o,
    output logic [31:0]      rdata_o,
    output logic [1:0]       rresp_o,
    output logic             rvalid_o,
    input  wire logic        rready_i,
    output logic             request_to_send_n_o,
    output logic             send_xon_o,
    output logic             send_xoff_o,
    output logic             loopback_o,
    output logic             irq_o
);
    typedef enum logic [1:0] {FLOW_RUN = 2'b01, FLOW_HALT = 2'b10} flow_state_t;

    logic        rst_meta_q;
    logic        rst_n_q;
    logic [7:0]  modem_control_reg_q;
    logic [7:0]  enhanced_feature_reg_q;
    logic [7:0]  special_feature_reg_q;
    logic [7:0]  flow_halt_resume_levels_q;
    logic [1:0]  flow_enable_q;
    logic [3:0]  delta_q;
    logic [1:0]  irq_status_q;
    logic [1:0]  irq_mask_q;
    flow_state_t flow_q;
    logic        aw_held_q;
    logic        w_held_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        xoff_pend_q;
    logic        xon_pend_q;
    logic [3:0]  status_hi;
    logic [3:0]  new_delta;
    logic [7:0]  modem_line_status;
    logic        levels_open;
    logic        wr_fire;
    logic        rd_fire;
    logic        rd_status;
    logic        rd_irq;
    logic [7:0]  resume_lvl;
    logic [7:0]  halt_lvl;
    logic [7:0]  fifo_cnt;
    logic        loop_on;
    logic [1:0]  irq_event;
    logic [31:0] rd_word;
    logic        rd_ok;
    logic        wr_ok;

    modem_in_if mi ();

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // Bit order cts, dsr, ri, cd matches status bits 0..3
    modem_input_sync u_sync (
        .clk_i   (core_clk_i),
        .rst_n_i (rst_n_q),
        .pins_n_i({carrier_detect_n_i, ring_indicator_n_i,
                   data_set_ready_n_i, clear_to_send_n_i}),
        .mi      (mi)
    );

    assign loop_on = modem_control_reg_q[MCR_LOOP_BIT]; // [R17]

    // Status high nibble: pins inverted, or control bits in loopback
    always_comb
    begin
        if (loop_on)
        begin
            status_hi[3] = modem_control_reg_q[MCR_OP2_BIT]; // [R1]
            status_hi[2] = modem_control_reg_q[MCR_OP1_BIT]; // [R2]
            status_hi[1] = modem_control_reg_q[MCR_DTR_BIT]; // [R3]
            status_hi[0] = modem_control_reg_q[MCR_RTS_BIT]; // [R4]
        end
        else
        begin
            status_hi[3] = mi.level[3]; // [R1]
            status_hi[2] = mi.level[2]; // [R2]
            status_hi[1] = mi.level[1]; // [R3]
            status_hi[0] = mi.level[0]; // [R4]
        end
    end

    // Deltas follow the pins only; loopback changes do not flag
    assign new_delta[3] = mi.delta[3]; // [R5]
    assign new_delta[2] = mi.delta[2] & mi.level[2] == 1'b0; // [R6]
    assign new_delta[1] = mi.delta[1]; // [R7]
    assign new_delta[0] = mi.delta[0]; // [R8]
    assign modem_line_status = {status_hi, delta_q};

    assign levels_open = enhanced_feature_reg_q[EFR_ENH_BIT]
                       & modem_control_reg_q[MCR_OP1_BIT]
                       & ~special_feature_reg_q[SFR_SEL_BIT]; // [R10]

    assign wr_fire   = aw_held_q & w_held_q & ~bvalid_o;
    assign rd_fire   = arvalid_i & arready_o;
    assign rd_status = rd_fire & araddr_i == ADDR_MODEM_LINE_STATUS;
    assign rd_irq    = rd_fire & araddr_i == ADDR_IRQ_STATUS;

    // Set wins over the read-clear
    always_ff @(posedge core_clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
            delta_q <= 4'h0;
        else
            delta_q <= (rd_status ? 4'h0 : delta_q) | new_delta; // [R18]
    end

    // Write channel: address and data taken in either order
    always_ff @(posedge core_clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            awready_o <= 1'b0;
            wready_o  <= 1'b0;
            bvalid_o  <= 1'b0;
            bresp_o   <= RESP_OKAY;
        end
        else
        begin
            awready_o <= ~aw_held_q & ~(awvalid_i & awready_o) & ~bvalid_o;
            wready_o  <= ~w_held_q & ~(wvalid_i & wready_o) & ~bvalid_o;
            if (awvalid_i & awready_o)
            begin
                aw_held_q <= 1'b1;
                aw_addr_q <= awaddr_i;
            end
            if (wvalid_i & wready_o)
            begin
                w_held_q <= 1'b1;
                w_data_q <= wdata_i;
                w_strb_q <= wstrb_i;
            end
            if (wr_fire)
            begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_o  <= 1'b1;
                bresp_o   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_o & bready_i)
                bvalid_o <= 1'b0;
        end
    end

    always_comb
    begin
        unique case (aw_addr_q)
            ADDR_FLOW_LEVELS:   wr_ok = levels_open;
            ADDR_MODEM_CONTROL: wr_ok = 1'b1;
            ADDR_FEATURE_CTRL:  wr_ok = 1'b1;
            ADDR_FIFO_FLOW:     wr_ok = 1'b1;
            ADDR_IRQ_MASK:      wr_ok = 1'b1;
            default:            wr_ok = 1'b0;
        endcase
    end

    // Control registers; only byte lane 0 (and 1 for feature) hold bits
    always_ff @(posedge core_clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            modem_control_reg_q       <= MCR_RESET;
            enhanced_feature_reg_q    <= EFR_RESET;
            special_feature_reg_q     <= SFR_RESET;
            flow_halt_resume_levels_q <= LEVEL_RESET;
            flow_enable_q             <= 2'h0;
            irq_mask_q                <= IRQ_RESET;
        end
        else if (wr_fire & wr_ok)
        begin
            unique case (aw_addr_q)
                ADDR_FLOW_LEVELS:
                    if (w_strb_q[0]) flow_halt_resume_levels_q <= w_data_q[7:0]; // [R10]
                ADDR_MODEM_CONTROL:
                    if (w_strb_q[0]) modem_control_reg_q <= w_data_q[7:0];
                ADDR_FEATURE_CTRL:
                begin
                    if (w_strb_q[0]) enhanced_feature_reg_q <= w_data_q[7:0];
                    if (w_strb_q[1]) special_feature_reg_q <= w_data_q[15:8];
                end
                ADDR_FIFO_FLOW:
                    if (w_strb_q[0]) flow_enable_q <= w_data_q[1:0];
                ADDR_IRQ_MASK:
                    if (w_strb_q[0]) irq_mask_q <= w_data_q[1:0];
                default:
                    flow_enable_q <= flow_enable_q;
            endcase
        end
    end

    // Read answer
    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        unique case (araddr_i)
            ADDR_MODEM_LINE_STATUS: rd_word[7:0] = modem_line_status;
            ADDR_FLOW_LEVELS:
            begin
                rd_ok = levels_open; // [R10]
                if (levels_open)
                    rd_word[7:0] = flow_halt_resume_levels_q;
            end
            ADDR_MODEM_CONTROL: rd_word[7:0] = modem_control_reg_q;
            ADDR_FEATURE_CTRL:
                rd_word[15:0] = {special_feature_reg_q, enhanced_feature_reg_q};
            ADDR_FIFO_FLOW:
                rd_word[17:0] = {xoff_pend_q, request_to_send_n_o,
                                 1'b0, rx_fifo_count_i, 6'h00, flow_enable_q};
            ADDR_IRQ_STATUS: rd_word[1:0] = irq_status_q;
            ADDR_IRQ_MASK:   rd_word[1:0] = irq_mask_q;
            default:         rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            arready_o <= 1'b0;
            rvalid_o  <= 1'b0;
            rdata_o   <= 32'h0000_0000;
            rresp_o   <= RESP_OKAY;
        end
        else
        begin
            arready_o <= ~rvalid_o & ~rd_fire;
            if (rd_fire)
            begin
                rvalid_o <= 1'b1;
                rdata_o  <= rd_word;
                rresp_o  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (rvalid_o & rready_i)
                rvalid_o <= 1'b0;
        end
    end

    // Flow levels are scaled by four; count compared in 8 bits
    assign resume_lvl = 8'(flow_halt_resume_levels_q[7:4]) * 8'(LEVEL_SCALE);
    assign halt_lvl   = 8'(flow_halt_resume_levels_q[3:0]) * 8'(LEVEL_SCALE);
    assign fifo_cnt   = {1'b0, rx_fifo_count_i};

    // Resume also needs the count below halt, so equal levels settle on halt
    always_ff @(posedge core_clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
            flow_q <= FLOW_RUN;
        else
        begin
            unique case (flow_q)
                FLOW_RUN:
                    if (fifo_cnt >= halt_lvl)
                        flow_q <= FLOW_HALT; // [R13]
                FLOW_HALT:
                    if (fifo_cnt <= resume_lvl && fifo_cnt < halt_lvl)
                        flow_q <= FLOW_RUN; // [R11]
                default:
                    flow_q <= FLOW_RUN;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            request_to_send_n_o <= 1'b1;
            send_xon_o          <= 1'b0;
            send_xoff_o         <= 1'b0;
            xoff_pend_q         <= 1'b0;
            xon_pend_q          <= 1'b0;
            loopback_o          <= 1'b0;
        end
        else
        begin
            loopback_o <= loop_on;
            if (flow_enable_q[FLOW_RTS_EN])
                request_to_send_n_o <= flow_q == FLOW_HALT; // [R11] [R13]
            else
                request_to_send_n_o <= ~modem_control_reg_q[MCR_RTS_BIT];
            send_xoff_o <= 1'b0;
            send_xon_o  <= 1'b0;
            if (flow_enable_q[FLOW_SW_EN])
            begin
                if (flow_q == FLOW_HALT && !xoff_pend_q)
                begin
                    send_xoff_o <= 1'b1; // [R14]
                    xoff_pend_q <= 1'b1;
                end
                else if (flow_q == FLOW_RUN && xoff_pend_q)
                begin
                    send_xon_o  <= 1'b1; // [R12]
                    xoff_pend_q <= 1'b0;
                end
            end
            else
                xoff_pend_q <= 1'b0;
            xon_pend_q <= 1'b0;
        end
    end

    // Bit0 modem status, bit1 flow halt entered
    assign irq_event[0] = |new_delta; // [R9]
    assign irq_event[1] = flow_q == FLOW_RUN && fifo_cnt >= halt_lvl;

    always_ff @(posedge core_clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            irq_status_q <= IRQ_RESET;
            irq_o        <= 1'b0;
        end
        else
        begin
            irq_status_q <= (rd_irq ? 2'h0 : irq_status_q) | irq_event;
            irq_o        <= |(irq_status_q & irq_mask_q); // [R9]
        end
    end
endmodule : modem_status_flow

/* File: bench/modem_peer.sv */
`timescale 1ns/1ps
module modem_peer
(
    input  wire logic       clk_i,
    input  wire logic [3:0] want_n_i,
    output logic      [3:0] pins_n_o
);
    // Idle line: all modem inputs inactive high
    initial pins_n_o = 4'hf;

    // Lines move just after an edge, never mid-cycle
    always @(posedge clk_i)
    begin
        pins_n_o <= want_n_i;
    end
endmodule : modem_peer

/* File: bench/modem_status_flow_chk.sv */
`timescale 1ns/1ps
module modem_status_flow_chk
    import modem_flow_pkg::*;
(
    input wire logic        core_clk_i,
    input wire logic        rst_b_i,
    input wire logic [6:0]  rx_fifo_count_i,
    input wire logic        awvalid_i,
    input wire logic        awready_o,
    input wire logic        wvalid_i,
    input wire logic        wready_o,
    input wire logic [1:0]  bresp_o,
    input wire logic        bvalid_o,
    input wire logic        bready_i,
    input wire logic        arvalid_i,
    input wire logic        arready_o,
    input wire logic [31:0] rdata_o,
    input wire logic [1:0]  rresp_o,
    input wire logic        rvalid_o,
    input wire logic        rready_i,
    input wire logic        send_xon_o,
    input wire logic        send_xoff_o
);
    logic [6:0] cnt_q;
    logic [6:0] stop_cnt_q;
    logic       halted_q;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    // One cycle late, to line up with the registered pulses
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cnt_q <= 7'h00;
        else
            cnt_q <= rx_fifo_count_i;
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            halted_q   <= 1'b0;
            stop_cnt_q <= 7'h00;
        end
        else if (send_xoff_o)
        begin
            halted_q   <= 1'b1;
            stop_cnt_q <= cnt_q;
        end
        else if (send_xon_o)
            halted_q <= 1'b0;
    end

    sequence s_wr_beat;
        awvalid_i && awready_o && wvalid_i && wready_o;
    endsequence

    sequence s_rd_beat;
        arvalid_i && arready_o;
    endsequence

    a_write_answer: assert property (s_wr_beat |-> ##2 bvalid_o)
        else $error("write response not on time");
    a_read_answer: assert property (s_rd_beat |=> rvalid_o)
        else $error("read response not on time");
    a_bresp_hold: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
        else $error("write response dropped early");
    a_rdata_hold: assert property (rvalid_o && !rready_i |=>
        rvalid_o && $stable(rdata_o) && $stable(rresp_o))
        else $error("read response dropped early");
    a_aw_drop: assert property (s_wr_beat |=> !awready_o [*2])
        else $error("address ready back too soon");
    a_xoff_single: assert property (send_xoff_o |=> !send_xoff_o)
        else $error("halt pulse too long");
    a_xon_single: assert property (send_xon_o |=> !send_xon_o)
        else $error("resume pulse too long");
    a_pulse_excl: assert property (!(send_xon_o && send_xoff_o))
        else $error("halt and resume together");
    a_xon_after_xoff: assert property (send_xon_o |-> halted_q)
        else $error("resume without halt");
    a_xon_lower: assert property (send_xon_o |-> cnt_q < stop_cnt_q)
        else $error("resume at a count not below halt");
endmodule : modem_status_flow_chk

bind modem_status_flow modem_status_flow_chk modem_status_flow_chk_i (
    .core_clk_i, .rst_b_i, .rx_fifo_count_i, .awvalid_i, .awready_o, .wvalid_i,
    .wready_o, .bresp_o, .bvalid_o, .bready_i, .arvalid_i, .arready_o, .rdata_o,
    .rresp_o, .rvalid_o, .rready_i, .send_xon_o, .send_xoff_o);

/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb;
    import modem_flow_pkg::*;
    logic        core_clk;
    logic        rst_b = 1'b0;
    logic [3:0]  want_n = 4'hf;
    logic [3:0]  pins_n;
    logic [6:0]  fifo_cnt = 7'h00;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic        rts_n, xon, xoff, loop_on, irq;
    int          bad_count = 0;
    int          checks = 0;

    modem_peer modem_peer_i (.clk_i(core_clk), .want_n_i(want_n), .pins_n_o(pins_n));

    modem_status_flow modem_status_flow_i (
        .core_clk_i(core_clk), .rst_b_i(rst_b), .carrier_detect_n_i(pins_n[3]),
        .ring_indicator_n_i(pins_n[2]), .data_set_ready_n_i(pins_n[1]),
        .clear_to_send_n_i(pins_n[0]), .rx_fifo_count_i(fifo_cnt),
        .awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(awready), .wdata_i(wdata),
        .wstrb_i(4'hf), .wvalid_i(wvalid), .wready_o(wready), .bresp_o(bresp),
        .bvalid_o(bvalid), .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid),
        .arready_o(arready), .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid),
        .rready_i(rready), .request_to_send_n_o(rts_n), .send_xon_o(xon),
        .send_xoff_o(xoff), .loopback_o(loop_on), .irq_o(irq));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // st delays the response ready, so the slave must hold its answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er,
                      input int st);
        int n;
        n = 0;
        @(posedge core_clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= (st == 0);
        do
        begin
            @(posedge core_clk);
            n++;
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (n == st)
                bready <= 1'b1;
        end while (!(bvalid && bready) && n < 60);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input logic [1:0] er, input int st);
        int n;
        n = 0;
        @(posedge core_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= (st == 0);
        do
        begin
            @(posedge core_clk);
            n++;
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (n == st)
                rready <= 1'b1;
        end while (!(rvalid && rready) && n < 60);
        chk("rdata", e, rdata & m);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        rready <= 1'b0;
    endtask : rd

    task automatic t_gate();
        logic [7:0]  modem_control_reg [3] = '{8'h04, 8'h00, 8'h04};
        logic [15:0] feat [3] = '{16'h0400, 16'h0010, 16'h0000};
        rd(ADDR_MODEM_LINE_STATUS, 32'hff, 32'h0, RESP_OKAY, 0);
        rd(ADDR_MODEM_CONTROL, 32'hff, {24'h0, MCR_RESET}, RESP_OKAY, 0);
        rd(ADDR_FEATURE_CTRL, 32'hffff, {16'h0, SFR_RESET, EFR_RESET}, RESP_OKAY, 0);
        for (int i = 0; i < 3; i++)
        begin
            wr(ADDR_MODEM_CONTROL, {24'h0, modem_control_reg[i]}, RESP_OKAY, 0);
            wr(ADDR_FEATURE_CTRL, {16'h0, feat[i]}, RESP_OKAY, 0);
            wr(ADDR_FLOW_LEVELS, 32'h5a, RESP_SLVERR, 0);
            rd(ADDR_FLOW_LEVELS, 32'hff, 32'h0, RESP_SLVERR, 0);
        end
        wr(ADDR_FEATURE_CTRL, 32'h10, RESP_OKAY, 0);
        // Resume 4 kept below halt 12
        wr(ADDR_FLOW_LEVELS, 32'h13, RESP_OKAY, 2);
        rd(ADDR_FLOW_LEVELS, 32'hff, 32'h13, RESP_OKAY, 3);
        rd(8'h1c, 32'hffffffff, 32'h0, RESP_SLVERR, 0);
        wr(8'h1c, 32'h1, RESP_SLVERR, 0);
        $display("test gate done");
    endtask : t_gate

    task automatic t_delta();
        logic [31:0] lvl;
        logic [31:0] dl;
        wr(ADDR_IRQ_MASK, 32'h1, RESP_OKAY, 0);
        for (int k = 3; k >= 0; k--)
        begin
            lvl = 32'h1 << (k + 4);
            dl = (k == 2) ? 32'h0 : 32'h1 << k;
            want_n[k] <= 1'b0;
            repeat (8) @(posedge core_clk);
            chk("irq", {31'h0, |dl}, {31'h0, irq});
            rd(ADDR_MODEM_LINE_STATUS, 32'hff, lvl | dl, RESP_OKAY, k);
            rd(ADDR_MODEM_LINE_STATUS, 32'hff, lvl, RESP_OKAY, 0);
            rd(ADDR_IRQ_STATUS, 32'h1, dl >> k, RESP_OKAY, 0);
            repeat (3) @(posedge core_clk);
            chk("irq", 32'h0, {31'h0, irq});
            want_n[k] <= 1'b1;
            repeat (8) @(posedge core_clk);
            rd(ADDR_MODEM_LINE_STATUS, 32'hff, 32'h1 << k, RESP_OKAY, 0);
            rd(ADDR_IRQ_STATUS, 32'h1, 32'h1, RESP_OKAY, 0);
        end
        wr(ADDR_IRQ_MASK, 32'h0, RESP_OKAY, 0);
        want_n[0] <= 1'b0;
        repeat (8) @(posedge core_clk);
        chk("irq", 32'h0, {31'h0, irq});
        rd(ADDR_IRQ_STATUS, 32'h1, 32'h1, RESP_OKAY, 0);
        rd(ADDR_MODEM_LINE_STATUS, 32'hff, 32'h11, RESP_OKAY, 0);
        $display("test delta done");
    endtask : t_delta

    task automatic t_loop();
        logic [7:0] modem_control_reg [3] = '{8'h1f, 8'h15, 8'h1a};
        logic [7:0] hi [3] = '{8'hf0, 8'h60, 8'h90};
        for (int i = 0; i < 3; i++)
        begin
            wr(ADDR_MODEM_CONTROL, {24'h0, modem_control_reg[i]}, RESP_OKAY, 0);
            repeat (2) @(posedge core_clk);
            chk("loopback", 32'h1, {31'h0, loop_on});
            rd(ADDR_MODEM_LINE_STATUS, 32'hf0, {24'h0, hi[i]}, RESP_OKAY, 0);
        end
        wr(ADDR_MODEM_CONTROL, 32'h04, RESP_OKAY, 0);
        repeat (2) @(posedge core_clk);
        chk("loopback", 32'h0, {31'h0, loop_on});
        rd(ADDR_MODEM_LINE_STATUS, 32'hf0, 32'h10, RESP_OKAY, 0);
        $display("test loop done");
    endtask : t_loop

    task automatic t_flow();
        int         cnt [4] = '{11, 12, 5, 4};
        logic [2:0] ex [4] = '{3'b000, 3'b110, 3'b100, 3'b001};
        int         nf;
        int         nx;
        wr(ADDR_FIFO_FLOW, 32'h3, RESP_OKAY, 0);
        for (int i = 0; i < 4; i++)
        begin
            fifo_cnt <= 7'(cnt[i]);
            nf = 0;
            nx = 0;
            repeat (8)
            begin
                @(posedge core_clk);
                nf += xoff;
                nx += xon;
            end
            chk("xoff", {31'h0, ex[i][1]}, nf);
            chk("xon", {31'h0, ex[i][0]}, nx);
            chk("rts_n", {31'h0, ex[i][2]}, {31'h0, rts_n});
        end
        $display("test flow done");
    endtask : t_flow

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test

    initial
    begin
        #200000;
        bad_count++;
        stop_test();
    end

    initial
    begin
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_gate();
        t_delta();
        t_loop();
        t_flow();
        stop_test();
    end
endmodule : tb
